// ### design/errirq_cmd.sv
// Error-clear and interrupt command interpreter with Avalon-MM register port
// Behaviour
// R1: Instruction 36 clears the error flags chosen by type; bank and value ignored.
// R2: Wipe type 0 clears all, 1..5 timeout, alarm, deviation, position, shutdown.
// R3: Instruction 25 enables the single interrupt numbered by type; other fields ignored.
// R4: Enable with number 255 turns interrupt processing on globally.
// R5: Instruction 26 disables the single interrupt numbered by type; other fields ignored.
// R6: Disable with number 255 turns interrupt processing off globally.
// R7: Instruction 37 stores value as handler entry address of interrupt type.
// R8: A later handler definition for the same number overwrites the earlier one.
// R9: Instruction 38 ends the running handler and resumes the interrupted program.
// R10: Handler return restores accumulator, X register, flags and program counter saved at entry.
// R11: Handler definition and return are used only by the stored program; the code also executes them from checked frames.
// R12: Every handler ends with a return; execution never falls into handler code.
// R13: In direct mode each of these instructions answers status 100, value meaningless.
// R14: A frame is address, instruction, type, bank, four value bytes MSB first, checksum.
// R15: Checksum is the 8-bit sum of eight bytes, checked before execution.
`timescale 1ns/100ps
`include "errirq_consts.svh"

// ****************************************
// Register map
// ****************************************
// 0x00 frame byte in, write only, low byte used
// 0x04 last reply: status 7:0, valid 8, instruction 23:16
// 0x08 error flags, read only
// 0x0c interrupt enables 15:0, global enable 16
// 0x10 event status, write one to clear: reply, bad checksum, return
// 0x14 event mask, same layout as status
// 0x18 handler table index for reads
// 0x1c handler address at that index
// 0x20 control: bit 0 drops a partly written frame
// Other offsets read zero and ignore writes

// ****************************************
// Timing
// ****************************************
// Each bus access takes two cycles: one wait state, then the answer
// A checked frame executes one cycle after its checksum byte lands
// While it executes the program port is held off for that cycle
// Program instructions take effect on the edge that accepts them
// Unknown frame instructions answer status 2, bad checksums status 1
// A new error or event in the clear cycle wins over the clear

module errirq_cmd (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic prog_valid,
  output logic prog_ready,
  input wire errirq_pkg::cmd_t prog_cmd,
  input wire logic [`FLG_W-1:0] err_set,
  output logic [`FLG_W-1:0] err_flags,
  output logic [`IRQ_NUM-1:0] irq_en,
  output logic irq_global,
  input wire logic [`IRQ_IDX_W-1:0] set_handler_cmd_num,
  output logic [31:0] set_handler_cmd_addr,
  input wire logic ctx_save,
  input wire errirq_pkg::ctx_t ctx_in,
  output logic ctx_restore,
  output errirq_pkg::ctx_t ctx_out,
  output logic in_handler,
  output logic irq
);

  errirq_pkg::state_t q;
  errirq_pkg::state_t s;

  // ****************************************
  // Combinational next state
  // ****************************************
  logic busreq;
  logic wr;
  logic go;
  logic from_frame;
  logic bad_op;
  errirq_pkg::cmd_t cmd;
  logic [`FLG_W-1:0] clr;
  logic [`EV_W-1:0] ev;
  logic [`EV_W-1:0] w1c;
  logic [7:0] fbyte;
  logic idx_ok;
  logic [`IRQ_IDX_W-1:0] idx;

  always_comb begin
    s = q;
    s.restore = 1'b0;
    clr = '0;
    ev = '0;
    w1c = '0;
    bad_op = 1'b0;
    busreq = avs_read | avs_write;
    // One wait state: data and write effect land on the edge where waitrequest is low
    s.ack = busreq & ~q.ack;
    wr = avs_write & q.ack;
    fbyte = avs_writedata[7:0];

    // ****************************************
    // Register read mux
    // ****************************************
    if (avs_read && !q.ack) begin
      case (avs_address)
        `REG_REPLY: begin
          s.rdata = `READ_ZERO;
          s.rdata[7:0] = q.reply;
          s.rdata[`REPLY_VALID_BIT] = q.reply_v;
          s.rdata[`REPLY_OP_LSB +: 8] = q.reply_op;
        end
        `REG_ERR: begin
          s.rdata = `READ_ZERO;
          s.rdata[`FLG_W-1:0] = q.err;
        end
        `REG_IRQEN: begin
          s.rdata = `READ_ZERO;
          s.rdata[`IRQ_NUM-1:0] = q.en;
          s.rdata[`IRQEN_GLOBAL_BIT] = q.glob;
        end
        `REG_STAT: begin
          s.rdata = `READ_ZERO;
          s.rdata[`EV_W-1:0] = q.stat;
        end
        `REG_MASK: begin
          s.rdata = `READ_ZERO;
          s.rdata[`EV_W-1:0] = q.mask;
        end
        `REG_VSEL: begin
          s.rdata = `READ_ZERO;
          s.rdata[`IRQ_IDX_W-1:0] = q.vsel;
        end
        `REG_VDATA: begin
          s.rdata = q.vec[q.vsel];
        end
        default: begin
          s.rdata = `READ_ZERO;
        end
      endcase
    end

    // ****************************************
    // Frame collector
    // ****************************************
    if (wr && avs_address == `REG_FRAME) begin
      s.cnt = q.cnt + 4'h1;
      s.sum = q.sum + fbyte;  // see R15
      case (q.cnt)
        `FRAME_ADDR: begin
          s.tgt = fbyte;
        end
        `FRAME_OP: begin
          s.frm.op = fbyte;  // see R14
        end
        `FRAME_TYPE: begin
          s.frm.typ = fbyte;
        end
        `FRAME_BANK: begin
          s.frm.bank = fbyte;
        end
        `FRAME_SUM: begin
          s.cnt = '0;
          s.sum = '0;
          if (q.tgt == `MODULE_ADDR) begin
            if (fbyte == q.sum) begin
              s.pend = 1'b1;  // see R15
            end else begin
              s.reply = `ST_BAD_SUM;
              s.reply_op = q.frm.op;
              s.reply_v = 1'b1;
              ev[`EV_BAD_SUM] = 1'b1;
            end
          end
        end
        default: begin
          s.frm.value = {q.frm.value[23:0], fbyte};  // see R14
        end
      endcase
    end
    if (wr && avs_address == `REG_CTRL && avs_writedata[`CTRL_ABORT_BIT]) begin
      s.cnt = '0;
      s.sum = '0;
    end

    // ****************************************
    // Executor: a checked frame goes before the stored program
    // ****************************************
    from_frame = q.pend;
    go = q.pend | prog_valid;
    cmd = q.pend ? q.frm : prog_cmd;
    idx_ok = (cmd.typ < 8'(`IRQ_NUM));
    idx = cmd.typ[`IRQ_IDX_W-1:0];
    if (from_frame) begin
      s.pend = 1'b0;
    end
    if (go) begin
      case (cmd.op)
        `OP_FLAG_WIPE: begin
          if (cmd.typ == `WIPE_ALL) begin
            clr = '1;  // see R1 see R2
          end else if (cmd.typ >= `WIPE_FIRST && cmd.typ <= `WIPE_LAST) begin
            clr[3'(cmd.typ - `WIPE_FIRST)] = 1'b1;  // see R2
          end
        end
        `OP_ENABLE_IRQ: begin
          if (cmd.typ == `IRQ_GLOBAL) begin
            s.glob = 1'b1;  // see R4
          end else if (idx_ok) begin
            s.en[idx] = 1'b1;  // see R3
          end
        end
        `OP_MASK_IRQ: begin
          if (cmd.typ == `IRQ_GLOBAL) begin
            s.glob = 1'b0;  // see R6
          end else if (idx_ok) begin
            s.en[idx] = 1'b0;  // see R5
          end
        end
        `OP_SET_HANDLER: begin
          if (idx_ok) begin
            s.vec[idx] = cmd.value;  // see R7 see R8
          end
        end
        `OP_HANDLER_RETURN: begin
          // A return outside a handler has nothing to restore
          if (q.inh) begin
            s.restore = 1'b1;  // see R9
            s.cout = q.ctx;  // see R10
            s.inh = 1'b0;
            ev[`EV_RETURN] = 1'b1;
          end
        end
        default: begin
          bad_op = 1'b1;
        end
      endcase
    end
    if (from_frame) begin
      s.reply = bad_op ? `ST_BAD_CMD : `ST_OK;  // see R13
      s.reply_op = cmd.op;
      s.reply_v = 1'b1;
      ev[`EV_REPLY] = 1'b1;
    end

    // ****************************************
    // Context capture at handler entry
    // ****************************************
    if (ctx_save) begin
      s.ctx = ctx_in;
      s.inh = 1'b1;
    end

    // ****************************************
    // Error flags: a new error wins over a wipe
    // ****************************************
    s.err = (q.err & ~clr) | err_set;

    // ****************************************
    // Event status, mask and vector select
    // ****************************************
    if (wr && avs_address == `REG_STAT) begin
      w1c = avs_writedata[`EV_W-1:0];
    end
    s.stat = (q.stat & ~w1c) | ev;
    if (wr && avs_address == `REG_MASK) begin
      s.mask = avs_writedata[`EV_W-1:0];
    end
    if (wr && avs_address == `REG_VSEL) begin
      s.vsel = avs_writedata[`IRQ_IDX_W-1:0];
    end
    s.vout = q.vec[set_handler_cmd_num];
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_waitrequest = busreq & ~q.ack;
  assign avs_readdata = q.rdata;
  assign prog_ready = ~q.pend;
  assign err_flags = q.err;
  assign irq_en = q.en;
  assign irq_global = q.glob;
  assign set_handler_cmd_addr = q.vout;
  assign ctx_restore = q.restore;
  assign ctx_out = q.cout;
  assign in_handler = q.inh;
  assign irq = |(q.stat & q.mask);

endmodule

// ### shared/errirq_consts.svh
// Constants of the error-clear and interrupt command block
`ifndef ERRIRQ_CONSTS_SVH
`define ERRIRQ_CONSTS_SVH

// ****************************************
// Instruction codes
// ****************************************
`define OP_FLAG_WIPE 8'h24
`define OP_ENABLE_IRQ 8'h19
`define OP_MASK_IRQ 8'h1a
`define OP_SET_HANDLER 8'h25
`define OP_HANDLER_RETURN 8'h26

// ****************************************
// Type field codes
// ****************************************
`define WIPE_ALL 8'h00
`define WIPE_FIRST 8'h01
`define WIPE_LAST 8'h05
`define IRQ_GLOBAL 8'hff

// ****************************************
// Reply status codes
// ****************************************
`define ST_OK 8'h64
`define ST_BAD_SUM 8'h01
`define ST_BAD_CMD 8'h02

// ****************************************
// Frame layout
// ****************************************
`define FRAME_ADDR 4'h0
`define FRAME_OP 4'h1
`define FRAME_TYPE 4'h2
`define FRAME_BANK 4'h3
`define FRAME_SUM 4'h8
`define MODULE_ADDR 8'h01

// ****************************************
// Sizes
// ****************************************
`define IRQ_NUM 16
`define IRQ_IDX_W 4
`define FLG_W 5
`define EV_W 3

// ****************************************
// Register byte offsets
// ****************************************
`define REG_FRAME 6'h00
`define REG_REPLY 6'h04
`define REG_ERR 6'h08
`define REG_IRQEN 6'h0c
`define REG_STAT 6'h10
`define REG_MASK 6'h14
`define REG_VSEL 6'h18
`define REG_VDATA 6'h1c
`define REG_CTRL 6'h20

// ****************************************
// Field positions
// ****************************************
`define EV_REPLY 0
`define EV_BAD_SUM 1
`define EV_RETURN 2
`define REPLY_VALID_BIT 8
`define REPLY_OP_LSB 16
`define IRQEN_GLOBAL_BIT 16
`define CTRL_ABORT_BIT 0
`define READ_ZERO 32'h0000_0000

`endif

// ### shared/errirq_pkg.sv
// Types of the error-clear and interrupt command block
`include "errirq_consts.svh"

package errirq_pkg;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_t;

  typedef struct packed {
    logic [31:0] accum;
    logic [31:0] xreg;
    logic [31:0] flags;
    logic [31:0] pc;
  } ctx_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [3:0] cnt;
    logic [7:0] sum;
    logic [7:0] tgt;
    cmd_t frm;
    logic pend;
    logic [7:0] reply;
    logic [7:0] reply_op;
    logic reply_v;
    logic [`FLG_W-1:0] err;
    logic [`IRQ_NUM-1:0] en;
    logic glob;
    logic [`IRQ_NUM-1:0][31:0] vec;
    logic [31:0] vout;
    ctx_t ctx;
    logic inh;
    logic restore;
    ctx_t cout;
    logic [`EV_W-1:0] stat;
    logic [`EV_W-1:0] mask;
    logic [`IRQ_IDX_W-1:0] vsel;
  } state_t;

endpackage

// ### verif/errirq_checker.sv
// Assertion checker on the command interpreter ports
`timescale 1ns/100ps
`include "errirq_consts.svh"
module errirq_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic prog_valid,
  input wire logic prog_ready,
  input wire errirq_pkg::cmd_t prog_cmd,
  input wire logic [4:0] err_set,
  input wire logic [4:0] err_flags,
  input wire logic [15:0] irq_en,
  input wire logic irq_global,
  input wire logic [3:0] set_handler_cmd_num,
  input wire logic [31:0] set_handler_cmd_addr,
  input wire logic ctx_save,
  input wire logic ctx_restore,
  input wire logic in_handler
);
  logic tk;
  assign tk = prog_valid && prog_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_set_handler_cmd;
    tk && prog_cmd.op == `OP_SET_HANDLER && prog_cmd.typ < 8'h10 ##1 set_handler_cmd_num == $past(prog_cmd.typ[3:0]);
  endsequence
  sequence s_ret;
    tk && prog_cmd.op == `OP_HANDLER_RETURN && in_handler && !ctx_save;
  endsequence
  a_en_single: assert property (
    tk && prog_cmd.op == `OP_ENABLE_IRQ && prog_cmd.typ < 8'h10 |=> irq_en[$past(prog_cmd.typ[3:0])])
    else $error("single enable missed");
  a_mask_single: assert property (
    tk && prog_cmd.op == `OP_MASK_IRQ && prog_cmd.typ < 8'h10 |=> !irq_en[$past(prog_cmd.typ[3:0])])
    else $error("single disable missed");
  a_glob_on: assert property (
    tk && prog_cmd.op == `OP_ENABLE_IRQ && prog_cmd.typ == 8'hff |=> irq_global)
    else $error("global enable missed");
  a_glob_off: assert property (
    tk && prog_cmd.op == `OP_MASK_IRQ && prog_cmd.typ == 8'hff |=> !irq_global)
    else $error("global disable missed");
  a_wipe_all: assert property (
    tk && prog_cmd.op == `OP_FLAG_WIPE && prog_cmd.typ == 8'h00 && err_set == 5'h00 |=> err_flags == 5'h00)
    else $error("wipe all missed");
  a_wipe_one: assert property (
    tk && prog_cmd.op == `OP_FLAG_WIPE && prog_cmd.typ inside {[8'h01:8'h05]} && err_set == 5'h00
    |=> err_flags == ($past(err_flags) & ~(5'h01 << ($past(prog_cmd.typ[2:0]) - 3'h1))))
    else $error("single wipe wrong");
  a_set_handler_cmd_store: assert property (s_set_handler_cmd |=> set_handler_cmd_addr == $past(prog_cmd.value, 2))
    else $error("handler address wrong");
  a_ret_restore: assert property (s_ret |=> ctx_restore && !in_handler)
    else $error("return did not restore");
endmodule
bind errirq_cmd errirq_checker chk_u (.*);

// ### verif/errirq_cmd_tb.sv
// Self-checking testbench of the command interpreter
`timescale 1ns/100ps
`include "errirq_consts.svh"
module errirq_cmd_tb;
  logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest, prog_valid, prog_ready;
  logic irq_global, ctx_save, ctx_restore, in_handler, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, set_handler_cmd_addr, q, v;
  logic [4:0] err_set, err_flags, ex;
  logic [15:0] irq_en;
  logic [3:0] set_handler_cmd_num;
  errirq_pkg::cmd_t prog_cmd;
  errirq_pkg::ctx_t ctx_in, ctx_out, c;
  logic [7:0] ops [5] = '{`OP_FLAG_WIPE, `OP_ENABLE_IRQ, `OP_MASK_IRQ, `OP_SET_HANDLER, `OP_HANDLER_RETURN};
  integer seed = 10395;
  int fail_count = 0;
  int cmp_count = 0;
  int n;
  errirq_cmd dut_u (.*);
  prog_host prog_u (.sys_clk(sys_clk), .prog_ready(prog_ready), .prog_valid(prog_valid), .prog_cmd(prog_cmd));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task check(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task results;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] sum8(input logic [63:0] f);
    sum8 = 8'h00;
    for (int i = 0; i < 8; i++) sum8 += f[i*8 +: 8];
  endfunction
  function automatic logic [4:0] wiped(input logic [4:0] f, input int t);
    wiped = (t == 0) ? 5'h00 : f & ~(5'h01 << (t - 1));
  endfunction
  task bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
    bit w;
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      w = avs_waitrequest;
      q = avs_readdata;
      k++;
    end while (w !== 1'b0 && k < 50);
    if (k >= 50) begin
      fail_count++;
      results;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge sys_clk);
  endtask
  task frame(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val, input logic [7:0] st);
    logic [63:0] f;
    f = {`MODULE_ADDR, op, typ, 8'($random(seed)), val};
    for (int i = 7; i >= 0; i--) bus(1'b1, `REG_FRAME, {24'h0, f[i*8 +: 8]});
    bus(1'b1, `REG_FRAME, {24'h0, sum8(f) + (st == `ST_BAD_SUM ? 8'h01 : 8'h00)});
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `REG_REPLY, 32'h0);
    check(q[7:0] === st && q[8] === 1'b1 && q[23:16] === op, "reply wrong");
  endtask
  task pc(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val);
    bit ok;
    prog_u.issue({op, typ, 8'($random(seed)), val}, $random(seed) & 3, ok);
    if (!ok) begin
      fail_count++;
      results;
    end
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    results;
  end
  initial begin
    nrst = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_set = 5'h00;
    set_handler_cmd_num = 4'h0;
    ctx_save = 1'b0;
    ctx_in = '0;
    ex = 5'h00;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    check(prog_ready === 1'b1 && err_flags === 5'h00 && irq_en === 16'h0000, "reset values");
    check(irq === 1'b0 && irq_global === 1'b0 && in_handler === 1'b0 && ctx_restore === 1'b0, "reset outputs");
    for (int i = 0; i < 6; i++) begin
      n = $random(seed) & 15;
      pc(`OP_ENABLE_IRQ, 8'(n), $random(seed));
      check(irq_en[n] === 1'b1, "enable");
      pc(`OP_MASK_IRQ, 8'(n), $random(seed));
      check(irq_en[n] === 1'b0, "disable");
    end
    pc(`OP_ENABLE_IRQ, `IRQ_GLOBAL, 32'h0);
    check(irq_global === 1'b1, "global on");
    pc(`OP_MASK_IRQ, `IRQ_GLOBAL, 32'h0);
    check(irq_global === 1'b0, "global off");
    $display("Enable test done");
    for (int t = 5; t >= 0; t--) begin
      @(posedge sys_clk);
      err_set <= 5'($random(seed)) | 5'h01 << (t - 1);
      @(posedge sys_clk);
      ex = ex | err_set;
      err_set <= 5'h00;
      pc(`OP_FLAG_WIPE, 8'(t), $random(seed));
      ex = wiped(ex, t);
      check(err_flags === ex, "wipe");
    end
    $display("Wipe test done");
    n = $random(seed) & 15;
    v = $random(seed);
    @(posedge sys_clk);
    set_handler_cmd_num <= 4'(n);
    frame(`OP_SET_HANDLER, 8'(n), v, `ST_OK);
    check(set_handler_cmd_addr === v, "handler store");
    bus(1'b1, `REG_VSEL, 32'(n));
    bus(1'b0, `REG_VDATA, 32'h0);
    check(q === v, "handler read back");
    v = $random(seed);
    pc(`OP_SET_HANDLER, 8'(n), v);
    @(negedge sys_clk);
    check(set_handler_cmd_addr === v, "handler address");
    c = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge sys_clk);
    ctx_in <= c;
    ctx_save <= 1'b1;
    @(posedge sys_clk);
    ctx_save <= 1'b0;
    ctx_in <= ~c;
    @(negedge sys_clk);
    check(in_handler === 1'b1, "handler entry");
    pc(`OP_HANDLER_RETURN, 8'hff, 32'h0);
    check(ctx_restore === 1'b1 && ctx_out === c && in_handler === 1'b0, "context restore");
    @(negedge sys_clk);
    check(ctx_restore === 1'b0 && ctx_out === c, "restore pulse");
    $display("Handler test done");
    frame(`OP_ENABLE_IRQ, 8'h02, 32'h0, `ST_BAD_SUM);
    check(irq_en[2] === 1'b0, "bad frame executed");
    bus(1'b1, `REG_FRAME, 32'h0000_0001);
    bus(1'b1, `REG_CTRL, 32'h0000_0001);
    frame(8'h07, 8'h00, 32'h0, `ST_BAD_CMD);
    for (int i = 0; i < 5; i++) frame(ops[i], 8'h00, 32'h0, `ST_OK);
    bus(1'b1, `REG_STAT, 32'h7);
    bus(1'b1, `REG_MASK, 32'h1);
    frame(`OP_FLAG_WIPE, 8'h01, 32'h0, `ST_OK);
    check(irq === 1'b1, "irq raise");
    bus(1'b1, `REG_MASK, 32'h0);
    check(irq === 1'b0, "irq mask");
    bus(1'b1, `REG_MASK, 32'h1);
    bus(1'b1, `REG_STAT, 32'h1);
    check(irq === 1'b0, "irq clear");
    bus(1'b0, 6'h3c, 32'h0);
    check(q === 32'h0, "unmapped read");
    $display("Frame test done");
    results;
  end
endmodule

// ### verif/prog_host.sv
// Stored-program model feeding the program port
`timescale 1ns/100ps
module prog_host (
  input wire logic sys_clk,
  input wire logic prog_ready,
  output logic prog_valid,
  output errirq_pkg::cmd_t prog_cmd
);
  initial begin
    prog_valid = 1'b0;
    prog_cmd = '0;
  end
  // Holds one instruction until taken, then scrambles the idle bus
  task automatic issue(input errirq_pkg::cmd_t c, input int stall, output bit took);
    took = 1'b0;
    repeat (stall + 1) @(posedge sys_clk);
    prog_valid <= 1'b1;
    prog_cmd <= c;
    for (int n = 0; n < 50 && !took; n++) begin
      @(posedge sys_clk);
      took = prog_ready;
    end
    prog_valid <= 1'b0;
    prog_cmd <= ~c;
  endtask
endmodule
